// ### bsc_pkg.sv
// bsc_pkg.sv: constants and types of the brushless speed controller
package bsc_pkg;
  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_NS = 40;
  localparam int SP_MIN_HZ = 500;
  localparam int SP_MAX_HZ = 18_000;
  localparam int SP_MAX_PER = CLK_HZ / SP_MIN_HZ;
  localparam int SP_MIN_PER = (CLK_HZ + SP_MAX_HZ - 1) / SP_MAX_HZ;
  localparam int PWM_HZ = 96_000;
  localparam int PWM_PER = CLK_HZ / PWM_HZ;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam int HALL_TMO = 8_388_607;
  // motor geometry: 3 sensors, 2 pole pairs
  localparam int EDGES_PER_REV = 12;
  localparam int EDGES_PER_HALF = 3;
  localparam int FG_DIV_2PPR = EDGES_PER_REV / 4;
  localparam logic [31:0] RPM_K = 32'(60 * CLK_HZ / EDGES_PER_REV);
  // scaled after the divide: the plain int product would overflow
  localparam logic [31:0] RPM_K_AVG = 32'(EDGES_PER_HALF) * RPM_K;
  // duty in 1/1024 steps, thresholds in tenths of a percent
  localparam int DUTY_FRAC = 10;
  localparam int STOP_PML = 20;
  localparam int RUN_PML = 30;
  localparam logic [10:0] DUTY_FULL_Q = 11'(1 << DUTY_FRAC);
  localparam logic [10:0] DUTY_STOP_Q = 11'(STOP_PML * 1024 / 1000);
  localparam logic [10:0] DUTY_RUN_Q = 11'(RUN_PML * 1024 / 1000 + 1);
  localparam logic [12:0] ERR_DLY_MAX = 13'h13EC;
  // register indices
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_MAXSPD = 4'h1;
  localparam logic [3:0] REG_FIXSPD = 4'h2;
  localparam logic [3:0] REG_ERRDLY = 4'h3;
  localparam logic [3:0] REG_SPEED = 4'h4;
  localparam logic [3:0] REG_TARGET = 4'h5;
  localparam logic [3:0] REG_DRIVE = 4'h6;
  // configuration bits
  localparam int CFG_SP_PWM = 0;
  localparam int CFG_OUT_ERR = 1;
  localparam int CFG_PPR2 = 2;
  localparam int CFG_NOBRAKE = 3;
  localparam int CFG_HALLAVG = 4;
  localparam int CFG_ANHALL = 5;
  localparam int CFG_MODE = 6;
  localparam logic [15:0] MAXSPD_RST = 16'h2710;
  localparam logic [15:0] FIXSPD_RST = 16'h0BB8;
  localparam logic [12:0] ERRDLY_RST = 13'h0064;
  // synchroniser lanes
  localparam int SYN_SP = 3;
  localparam int SYN_DIR = 4;

  typedef enum logic [1:0] {
    MODE_SPEED = 2'h0,
    MODE_FIXED = 2'h1,
    MODE_VOLT  = 2'h2
  } bsc_mode_type;

  typedef enum logic [2:0] {
    DIV_IDLE = 3'h1,
    DIV_RUN  = 3'h2,
    DIV_DONE = 3'h4
  } bsc_div_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bsc_req_type;

  typedef struct packed {
    logic [4:0]  syncA, syncB, syncC, filt;
    logic [2:0]  hallLast;
    logic [22:0] hallCnt, iv0, iv1, iv2;
    logic        speedReq, fg, spLast, spValid, dutyReq, run, divJob;
    logic [1:0]  edgeCnt;
    logic [16:0] spHigh, spPer, latHigh, latPer;
    logic [10:0] dutyQ;
    bsc_div_type divSt;
    logic [4:0]  divBit;
    logic [31:0] divNum, divDen, divQuo;
    logic [32:0] divRem;
    logic [15:0] actual, target, maxSpd, fixSpd;
    logic [8:0]  carrier, drive;
    logic        pwmOut, brake, errOut, dout, dirCcw;
    logic [14:0] msPre;
    logic [12:0] msCnt, errDly;
    logic [7:0]  cfg;
    logic [31:0] rdata;
  } bsc_state_type;

  localparam bsc_state_type ST_RST = '{syncA: 5'h1F, syncB: 5'h1F,
    syncC: 5'h1F, filt: 5'h1F, hallLast: 3'h7, maxSpd: MAXSPD_RST,
    fixSpd: FIXSPD_RST, errDly: ERRDLY_RST, divSt: DIV_IDLE,
    default: '0};
endpackage

// ### bsc_speed_ctrl.sv
// bsc_speed_ctrl.sv: speed loop, setpoint capture and output logic
// Function
// - PWM setpoint accepted between 500 Hz and 18 kHz carrier frequency.
// - PWM mode: stop below 2.0 % duty, run above 3.0 %, hold between.
// - target speed scales linearly with duty; full duty gives max speed.
// - configuration selects analog or PWM setpoint interpretation.
// - actual speed not driven above configured max target speed in speed and fixed-speed modes.
// - direction pin low gives anticlockwise, high or open clockwise.
// - configuration selects error or speed-pulse function of output.
// - after reset the output gives 6 speed pulses per revolution.
// - speed pulse rate selectable as 6 or 2 per revolution.
// - error mode: output high after configurable delay of current limit.
// - error mode: output low as soon as current limit ends.
// - power stage switched by PWM near 96 kHz.
// - actual speed computed from interval between Hall edges.
// - default two-quadrant with winding short for quick slowdown.
// - option disables winding short, leaving pure two-quadrant drive.
// - Hall filter option times a whole electrical half revolution.
// - analog Hall sensors allow four-quadrant active braking.
// - fixed-speed and voltage-controller modes besides speed control.
// - fixed-speed mode ignores setpoint and uses stored target.
// - error output delay accepts up to 5100 ms.
`timescale 1ns/10ps
module bsc_speed_ctrl
  import bsc_pkg::*;
#(
  parameter int SP_MAX_PER_CYC = SP_MAX_PER,
  parameter int MS_CYC_P       = MS_CYC,
  parameter int HALL_TMO_CYC   = HALL_TMO
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire bsc_req_type regReq,
  output logic [31:0]      regRdata,
  input  wire logic [2:0]  hallPin,
  input  wire logic        setpointPin,
  input  wire logic        dirPin,
  input  wire logic [9:0]  setpointAdc,
  input  wire logic        curLimit,
  output logic             drivePwm,
  output logic             brakeOut,
  output logic             dirCcw,
  output logic             speedPulseOut
);
  localparam logic [16:0] SP_MAXP = 17'(SP_MAX_PER_CYC);
  localparam logic [16:0] SP_MINP = 17'(SP_MIN_PER);
  localparam logic [22:0] HALL_TMO_C = 23'(HALL_TMO_CYC);
  localparam logic [14:0] MS_LAST = 15'(MS_CYC_P - 1);
  localparam logic [8:0]  PWM_LAST = 9'(PWM_PER - 1);
  localparam logic [8:0]  PWM_TOP = 9'(PWM_PER);

  bsc_state_type st_r;
  bsc_state_type st_nxt;
  logic          hallEdge;
  logic          spNow;
  logic [10:0]   qSel;
  logic [26:0]   spProd;
  logic [19:0]   voltProd;
  logic [15:0]   tgtCalc;
  logic [32:0]   divTry;
  logic [24:0]   ivSum;
  bsc_mode_type  mode;

  // combined next-state logic
  always_comb begin
    st_nxt = st_r;
    divTry = '0;
    mode = bsc_mode_type'(st_r.cfg[CFG_MODE +: 2]);
    hallEdge = (st_r.filt[2:0] != st_r.hallLast);
    spNow = st_r.filt[SYN_SP];
    ivSum = 25'(st_r.iv0) + 25'(st_r.iv1) + 25'(st_r.iv2);

    // three-stage pin synchronisers, change taken when stages 2 and 3 agree
    st_nxt.syncA = {dirPin, setpointPin, hallPin};
    st_nxt.syncB = st_r.syncA;
    st_nxt.syncC = st_r.syncB;
    for (int i = 0; i < 5; i++) begin
      if (st_r.syncB[i] == st_r.syncC[i]) begin
        st_nxt.filt[i] = st_r.syncB[i];
      end
    end
    st_nxt.hallLast = st_r.filt[2:0];
    st_nxt.dirCcw = !st_r.filt[SYN_DIR];

    // shared serial divider, one quotient bit per cycle
    case (st_r.divSt)
      DIV_IDLE: begin
        if (st_r.dutyReq) begin
          st_nxt.dutyReq = 1'b0;
          st_nxt.divJob = 1'b0;
          st_nxt.divNum = 32'({st_r.latHigh, 10'h000});
          st_nxt.divDen = 32'(st_r.latPer);
          st_nxt.divSt = DIV_RUN;
        end else if (st_r.speedReq) begin
          st_nxt.speedReq = 1'b0;
          st_nxt.divJob = 1'b1;
          if (st_r.cfg[CFG_HALLAVG]) begin
            st_nxt.divNum = RPM_K_AVG;
            st_nxt.divDen = 32'(ivSum);
          end else begin
            st_nxt.divNum = RPM_K;
            st_nxt.divDen = 32'(st_r.iv0);
          end
          st_nxt.divSt = DIV_RUN;
        end
        st_nxt.divRem = '0;
        st_nxt.divQuo = '0;
        st_nxt.divBit = 5'h1F;
      end
      DIV_RUN: begin
        divTry = {st_r.divRem[31:0], st_r.divNum[31]};
        st_nxt.divNum = {st_r.divNum[30:0], 1'b0};
        if (divTry >= {1'b0, st_r.divDen}) begin
          st_nxt.divRem = divTry - {1'b0, st_r.divDen};
          st_nxt.divQuo = {st_r.divQuo[30:0], 1'b1};
        end else begin
          st_nxt.divRem = divTry;
          st_nxt.divQuo = {st_r.divQuo[30:0], 1'b0};
        end
        st_nxt.divBit = st_r.divBit - 5'h01;
        if (st_r.divBit == 5'h00) begin
          st_nxt.divSt = DIV_DONE;
        end
      end
      DIV_DONE: begin
        st_nxt.divSt = DIV_IDLE;
        if (!st_r.divJob) begin
          if (st_r.divQuo > 32'(DUTY_FULL_Q)) begin
            st_nxt.dutyQ = DUTY_FULL_Q;
          end else begin
            st_nxt.dutyQ = st_r.divQuo[10:0];
          end
        end else if (st_r.divQuo > 32'h0000FFFF) begin
          st_nxt.actual = 16'hFFFF;
        end else begin
          st_nxt.actual = st_r.divQuo[15:0];
        end
      end
      default: begin
        st_nxt.divSt = DIV_IDLE;
      end
    endcase

    if (hallEdge) begin
      st_nxt.iv2 = st_r.iv1;
      st_nxt.iv1 = st_r.iv0;
      st_nxt.iv0 = st_r.hallCnt;
      st_nxt.hallCnt = '0;
      st_nxt.speedReq = 1'b1;
    end else if (st_r.hallCnt != HALL_TMO_C) begin
      st_nxt.hallCnt = st_r.hallCnt + 23'h000001;
    end else begin
      st_nxt.actual = '0; // standstill wins over a late quotient
    end

    if (hallEdge) begin
      if (st_r.cfg[CFG_PPR2] && st_r.edgeCnt != 2'(FG_DIV_2PPR - 1)) begin
        st_nxt.edgeCnt = st_r.edgeCnt + 2'h1;
      end else begin
        st_nxt.edgeCnt = '0;
        st_nxt.fg = !st_r.fg;
      end
    end

    st_nxt.spLast = spNow;
    if (spNow && !st_r.spLast) begin
      if (st_r.spValid && st_r.spPer >= SP_MINP) begin
        st_nxt.latHigh = st_r.spHigh;
        st_nxt.latPer = st_r.spPer;
        st_nxt.dutyReq = 1'b1;
      end
      st_nxt.spValid = 1'b1;
      st_nxt.spPer = 17'h00001;
      st_nxt.spHigh = 17'h00001;
    end else if (st_r.spPer < SP_MAXP) begin
      st_nxt.spPer = st_r.spPer + 17'h00001;
      if (spNow) begin
        st_nxt.spHigh = st_r.spHigh + 17'h00001;
      end
    end else begin
      // below 500 Hz the static level counts as 0 or 100 %
      st_nxt.spValid = 1'b0;
      st_nxt.dutyQ = spNow ? DUTY_FULL_Q : 11'h000;
    end

    if (!st_r.cfg[CFG_SP_PWM]) begin
      st_nxt.run = 1'b1;
    end else if (st_r.dutyQ <= DUTY_STOP_Q) begin
      st_nxt.run = 1'b0;
    end else if (st_r.dutyQ >= DUTY_RUN_Q) begin
      st_nxt.run = 1'b1;
    end

    qSel = st_r.cfg[CFG_SP_PWM] ? st_r.dutyQ : {1'b0, setpointAdc};
    spProd = st_r.maxSpd * qSel;
    tgtCalc = st_r.run ? spProd[25:10] : 16'h0000;
    if (mode == MODE_FIXED) begin
      tgtCalc = st_r.fixSpd;
    end
    if (tgtCalc > st_r.maxSpd) begin
      tgtCalc = st_r.maxSpd;
    end
    st_nxt.target = tgtCalc;
    voltProd = st_r.run ? qSel * PWM_TOP : 20'h00000;

    // carrier counter, loop updates once per carrier period
    if (st_r.carrier == PWM_LAST) begin
      st_nxt.carrier = '0;
      if (mode == MODE_VOLT) begin
        st_nxt.brake = 1'b0;
        if (curLimit && st_r.drive != 9'h000) begin
          st_nxt.drive = st_r.drive - 9'h001;
        end else begin
          st_nxt.drive = voltProd[18:10];
        end
      end else begin
        if (st_r.actual < st_r.target && !curLimit) begin
          if (st_r.drive != PWM_TOP) begin
            st_nxt.drive = st_r.drive + 9'h001;
          end
        end else if (st_r.actual > st_r.target || curLimit) begin
          if (st_r.drive != 9'h000) begin
            st_nxt.drive = st_r.drive - 9'h001;
          end
        end
        st_nxt.brake = (st_r.actual > st_r.target) &&
                       (!st_r.cfg[CFG_NOBRAKE] || st_r.cfg[CFG_ANHALL]);
      end
    end else begin
      st_nxt.carrier = st_r.carrier + 9'h001;
    end
    st_nxt.pwmOut = !st_r.brake && (st_r.carrier < st_r.drive);

    if (!curLimit) begin
      st_nxt.msPre = '0;
      st_nxt.msCnt = '0;
      st_nxt.errOut = 1'b0;
    end else if (st_r.msCnt >= st_r.errDly) begin
      st_nxt.errOut = 1'b1;
    end else if (st_r.msPre == MS_LAST) begin
      st_nxt.msPre = '0;
      st_nxt.msCnt = st_r.msCnt + 13'h0001;
    end else begin
      st_nxt.msPre = st_r.msPre + 15'h0001;
    end
    st_nxt.dout = st_r.cfg[CFG_OUT_ERR] ? st_nxt.errOut : st_nxt.fg;

    // register writes
    if (regReq.wr) begin
      case (regReq.addr)
        REG_CFG:    st_nxt.cfg = regReq.wdata[7:0];
        REG_MAXSPD: st_nxt.maxSpd = regReq.wdata[15:0];
        REG_FIXSPD: st_nxt.fixSpd = regReq.wdata[15:0];
        REG_ERRDLY: begin
          if (regReq.wdata > 32'(ERR_DLY_MAX)) begin
            st_nxt.errDly = ERR_DLY_MAX;
          end else begin
            st_nxt.errDly = regReq.wdata[12:0];
          end
        end
        default: ;
      endcase
    end
    // register reads, data only in the following cycle
    st_nxt.rdata = '0;
    if (regReq.rd) begin
      case (regReq.addr)
        REG_CFG:    st_nxt.rdata = 32'(st_r.cfg);
        REG_MAXSPD: st_nxt.rdata = 32'(st_r.maxSpd);
        REG_FIXSPD: st_nxt.rdata = 32'(st_r.fixSpd);
        REG_ERRDLY: st_nxt.rdata = 32'(st_r.errDly);
        REG_SPEED:  st_nxt.rdata = 32'(st_r.actual);
        REG_TARGET: st_nxt.rdata = 32'(st_r.target);
        REG_DRIVE:  st_nxt.rdata = {21'h000000, st_r.errOut, st_r.run,
                                    st_r.drive};
        default:    st_nxt.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign regRdata = st_r.rdata;
  assign drivePwm = st_r.pwmOut;
  assign brakeOut = st_r.brake;
  assign dirCcw = st_r.dirCcw;
  assign speedPulseOut = st_r.dout;

  a_run_stop : assert property (@(posedge clk) disable iff (!nrst)
    (st_r.cfg[CFG_SP_PWM] && st_r.dutyQ <= DUTY_STOP_Q) |=> !st_r.run)
    else $error("run flag kept below stop duty");
  a_run_hold : assert property (@(posedge clk) disable iff (!nrst)
    (st_r.cfg[CFG_SP_PWM] && st_r.dutyQ > DUTY_STOP_Q &&
     st_r.dutyQ < DUTY_RUN_Q) |=> st_r.run == $past(st_r.run))
    else $error("run flag changed inside hysteresis band");
  a_target_max : assert property (@(posedge clk) disable iff (!nrst)
    st_r.target <= $past(st_r.maxSpd))
    else $error("target above max speed");
  a_fixed_target : assert property (@(posedge clk) disable iff (!nrst)
    (mode == MODE_FIXED && st_r.fixSpd <= st_r.maxSpd)
    |=> st_r.target == $past(st_r.fixSpd))
    else $error("fixed mode target not stored value");
  a_fg_toggle : assert property (@(posedge clk) disable iff (!nrst)
    (!st_r.cfg[CFG_OUT_ERR] && !st_r.cfg[CFG_PPR2] && hallEdge)
    |=> speedPulseOut == !$past(st_r.fg))
    else $error("speed pulse missed a hall edge");
  a_err_release : assert property (@(posedge clk) disable iff (!nrst)
    (st_r.cfg[CFG_OUT_ERR] && !curLimit) |=> !speedPulseOut)
    else $error("error output stayed high after limit end");
  a_err_cause : assert property (@(posedge clk) disable iff (!nrst)
    $rose(st_r.errOut) |-> $past(curLimit) &&
    $past(st_r.msCnt) >= $past(st_r.errDly))
    else $error("error flag rose before delay elapsed");
  a_brake_pwm : assert property (@(posedge clk) disable iff (!nrst)
    st_r.brake |=> !drivePwm)
    else $error("drive and winding short together");
  a_carrier_wrap : assert property (@(posedge clk) disable iff (!nrst)
    st_r.carrier == PWM_LAST |=> st_r.carrier == 9'h000 ##259
    st_r.carrier == PWM_LAST)
    else $error("carrier period not 260 cycles");
  a_brake_slow : assert property (@(posedge clk) disable iff (!nrst)
    (st_r.carrier == PWM_LAST && mode != MODE_VOLT &&
     !st_r.cfg[CFG_NOBRAKE] && st_r.actual > st_r.target) |=> brakeOut)
    else $error("no winding short while slowing down");
  a_brake_off : assert property (@(posedge clk) disable iff (!nrst)
    (st_r.carrier == PWM_LAST && mode != MODE_VOLT &&
     st_r.cfg[CFG_NOBRAKE] && !st_r.cfg[CFG_ANHALL]) |=> !brakeOut)
    else $error("winding short despite no-brake option");
  a_brake_quad : assert property (@(posedge clk) disable iff (!nrst)
    (st_r.carrier == PWM_LAST && mode != MODE_VOLT &&
     st_r.cfg[CFG_ANHALL] && st_r.actual > st_r.target) |=> brakeOut)
    else $error("active braking missing with analog hall");
  a_volt_brake : assert property (@(posedge clk) disable iff (!nrst)
    (st_r.carrier == PWM_LAST && mode == MODE_VOLT) |=> !brakeOut)
    else $error("winding short in voltage mode");
  a_drive_hold : assert property (@(posedge clk) disable iff (!nrst)
    st_r.carrier != PWM_LAST |=> st_r.drive == $past(st_r.drive))
    else $error("duty changed inside a carrier period");
  a_drive_top : assert property (@(posedge clk) disable iff (!nrst)
    st_r.drive <= PWM_TOP)
    else $error("duty count above carrier period");
  a_duty_full : assert property (@(posedge clk) disable iff (!nrst)
    st_r.dutyQ <= DUTY_FULL_Q)
    else $error("measured duty above full scale");
  a_hall_stop : assert property (@(posedge clk) disable iff (!nrst)
    (st_r.hallCnt == HALL_TMO_C && !hallEdge) |=> st_r.actual == 16'h0000)
    else $error("speed not zero at standstill");
  a_err_set : assert property (@(posedge clk) disable iff (!nrst)
    (st_r.cfg[CFG_OUT_ERR] && curLimit && st_r.msCnt >= st_r.errDly)
    |=> speedPulseOut)
    else $error("error output low after delay elapsed");
  a_delay_cap : assert property (@(posedge clk) disable iff (!nrst)
    st_r.errDly <= ERR_DLY_MAX)
    else $error("error delay above its limit");
  a_dir_pin : assert property (@(posedge clk) disable iff (!nrst)
    (st_r.syncB[SYN_DIR] == st_r.syncC[SYN_DIR])
    |=> ##1 dirCcw == !$past(st_r.syncB[SYN_DIR], 2))
    else $error("direction does not follow settled pin");
endmodule

// ### bsc_ctrl_model.sv
// bsc_ctrl_model.sv: external controller driving setpoint pwm and direction
`timescale 1ns/10ps
module bsc_ctrl_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [15:0] perCyc,
  input  wire logic [15:0] highCyc,
  input  wire logic        dirLevel,
  output logic             setpointPin,
  output logic             dirPin
);
  logic [15:0] phase_r;
  logic [15:0] phase_nxt;

  // wrap the phase counter at the end of each carrier period
  assign phase_nxt = (phase_r + 16'h0001 >= perCyc) ? 16'h0000
                                                      : phase_r + 16'h0001;

  // setpoint carrier generation
  // period is kept inside the accepted band by the bench
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r     <= 16'h0000;
      setpointPin <= 1'b0;
    end else begin
      phase_r     <= phase_nxt;
      setpointPin <= (phase_r < highCyc); // zero high time gives static low
    end
  end

  // open pin reads high, so clockwise is the idle level
  assign dirPin = dirLevel;
endmodule

// ### bsc_speed_ctrl_bench.sv
// bsc_speed_ctrl_bench.sv: self-checking testbench of the speed controller
`timescale 1ns/10ps
module bsc_speed_ctrl_bench;
  import bsc_pkg::*;
  logic        clk;
  logic        nrst;
  bsc_req_type regReq;
  logic [31:0] regRdata;
  logic [2:0]  hallPin;
  logic        setpointPin;
  logic        dirPin;
  logic [9:0]  setpointAdc;
  logic        curLimit;
  logic        drivePwm;
  logic        brakeOut;
  logic        dirCcw;
  logic        speedPulseOut;
  logic [15:0] perCyc;
  logic [15:0] highCyc;
  logic        dirLevel;
  int          errTotal;
  int          totalChecks;
  logic [31:0] rd;
  int          n;
  logic [2:0]  hallSeq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int          hallIdx;
  // duty steps: high time, expected run flag
  logic [15:0] dutyHigh [5] = '{16'h000F, 16'h003C, 16'h0025, 16'h000F,
                                16'h0025};
  logic        runExp [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  // shortened counts keep the run well under the cycle budget
  bsc_speed_ctrl #(.SP_MAX_PER_CYC(2000), .MS_CYC_P(10),
                   .HALL_TMO_CYC(5000)) uut (
    .clk           (clk),
    .nrst          (nrst),
    .regReq        (regReq),
    .regRdata      (regRdata),
    .hallPin       (hallPin),
    .setpointPin   (setpointPin),
    .dirPin        (dirPin),
    .setpointAdc   (setpointAdc),
    .curLimit      (curLimit),
    .drivePwm      (drivePwm),
    .brakeOut      (brakeOut),
    .dirCcw        (dirCcw),
    .speedPulseOut (speedPulseOut)
  );

  bsc_ctrl_model ctrl (
    .clk         (clk),
    .nrst        (nrst),
    .perCyc      (perCyc),
    .highCyc     (highCyc),
    .dirLevel    (dirLevel),
    .setpointPin (setpointPin),
    .dirPin      (dirPin)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chkEq(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkRange(input logic [31:0] got, input logic [31:0] lo,
                          input logic [31:0] hi);
    totalChecks++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // one-cycle write strobe
  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic regRead(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1 d = regRdata;
  endtask

  // step the hall pattern and count speed output toggles
  task automatic hallRun(input int steps, input int dwell, output int tog);
    logic last;
    tog = 0;
    last = speedPulseOut;
    repeat (steps) begin
      hallIdx = (hallIdx + 1) % 6;
      hallPin <= hallSeq[hallIdx];
      repeat (dwell) begin
        @(posedge clk);
        #1 if (speedPulseOut !== last) tog++;
        last = speedPulseOut;
      end
    end
  endtask

  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk);
    errTotal++;
    testDone();
  end

  initial begin
    errTotal = 0;
    totalChecks = 0;
    hallIdx = 0;
    nrst = 1'b0;
    regReq = '0;
    hallPin = 3'h1;
    setpointAdc = 10'h000;
    curLimit = 1'b0;
    perCyc = 16'h05DC;
    highCyc = 16'h0000;
    dirLevel = 1'b1;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    // reset values, clamp and unmapped place
    regRead(REG_MAXSPD, rd); chkEq(rd, 32'h0000_2710); // max reset
    regRead(REG_FIXSPD, rd); chkEq(rd, 32'h0000_0BB8); // fixed reset
    regRead(REG_ERRDLY, rd); chkEq(rd, 32'h0000_0064); // delay reset
    regRead(REG_CFG, rd); chkEq(rd, 32'h0000_0000); // default output
    regWrite(REG_ERRDLY, 32'h0000_2000);
    regRead(REG_ERRDLY, rd); chkEq(rd, 32'h0000_13EC); // delay clamp
    regRead(4'hF, rd); chkEq(rd, 32'h0000_0000);
    regWrite(REG_MAXSPD, 32'h0000_0400);
    // direction pin both levels
    dirLevel <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chkEq({31'h0, dirCcw}, 32'h1); // low gives anticlockwise
    dirLevel <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chkEq({31'h0, dirCcw}, 32'h0); // high gives clockwise
    // speed pulses, default then two per revolution
    hallRun(2, 200, n);
    hallRun(12, 200, n); chkEq(n, 12); // six pulses per turn
    regWrite(REG_CFG, 32'h0000_0004);
    hallRun(3, 200, n);
    hallRun(12, 200, n); chkEq(n, 4); // two pulses per turn
    // 12 edges of 2500 cycles is 1.2 ms a turn, so 50000 rpm
    hallRun(3, 2500, n);
    regRead(REG_SPEED, rd); chkRange(rd, 32'd49990, 32'd50030);
    regWrite(REG_CFG, 32'h0000_0014); // averaging on
    hallRun(1, 2500, n);
    regRead(REG_SPEED, rd); chkRange(rd, 32'd49990, 32'd50030);
    // zero setpoint while turning fast, before standstill is declared
    repeat (300) @(posedge clk);
    #1 chkEq({30'h0, brakeOut, drivePwm}, 32'h2); // short, no drive
    regWrite(REG_CFG, 32'h0000_001C); // no-brake option
    repeat (300) @(posedge clk);
    #1 chkEq({31'h0, brakeOut}, 32'h0); // short disabled
    regWrite(REG_CFG, 32'h0000_003C); // analog hall fitted
    repeat (300) @(posedge clk);
    #1 chkEq({31'h0, brakeOut}, 32'h1); // active braking
    // analog full scale target
    regWrite(REG_CFG, 32'h0000_0000);
    setpointAdc <= 10'h3FF;
    repeat (50) @(posedge clk);
    regRead(REG_TARGET, rd); chkRange(rd, 32'd1020, 32'd1024); // cap
    // fixed-speed mode ignores the setpoint
    // stored value below the max, so the speed cap stays out of the way
    regWrite(REG_FIXSPD, 32'h0000_0123); // stored target
    regWrite(REG_CFG, 32'h0000_0040);
    repeat (50) @(posedge clk);
    regRead(REG_TARGET, rd); chkEq(rd, 32'h0000_0123); // stored target
    // voltage mode: half-scale setpoint gives 130 of 260 carrier steps
    setpointAdc <= 10'h200;
    regWrite(REG_CFG, 32'h0000_0080); // voltage mode
    repeat (300) @(posedge clk);
    regRead(REG_DRIVE, rd); chkEq(rd, 32'h0000_0282); // duty and run
    n = 0;
    repeat (260) begin
      @(posedge clk);
      #1 if (drivePwm === 1'b1) n++;
    end
    chkEq(n, 130); // high time per carrier period
    chkEq({31'h0, brakeOut}, 32'h0); // no short in voltage mode
    // pwm setpoint at half duty
    highCyc <= 16'h02EE;
    regWrite(REG_CFG, 32'h0000_0001);
    repeat (4500) @(posedge clk);
    regRead(REG_TARGET, rd); chkRange(rd, 32'd510, 32'd514); // half duty
    // stop and run thresholds with hysteresis hold
    for (int i = 0; i < 5; i++) begin
      highCyc <= dutyHigh[i];
      repeat (4500) @(posedge clk);
      regRead(REG_DRIVE, rd); chkEq({31'h0, rd[9]}, {31'h0, runExp[i]});
    end
    // delayed error flag: 2 ms of 10 cycles each
    regWrite(REG_ERRDLY, 32'h0000_0002);
    regWrite(REG_CFG, 32'h0000_0002);
    repeat (5) @(posedge clk);
    curLimit <= 1'b1;
    repeat (15) @(posedge clk);
    #1 chkEq({31'h0, speedPulseOut}, 32'h0); // still delayed
    n = 15;
    while (speedPulseOut !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chkRange(n, 32'd19, 32'd24); // delay length
    curLimit <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chkEq({31'h0, speedPulseOut}, 32'h0); // prompt release
    testDone();
  end
endmodule
